/* File: shared/qec_map.vh */
// Purpose: Constants for the quadrature encoder counter block.
// Assumes: Included by the design file and the checker by its bare name.
// Notes: Offsets are bytes within the 16-byte host window.
`ifndef QEC_MAP_VH
`define QEC_MAP_VH
`define QEC_CNT_W 24
`define QEC_AXES 4
`define QEC_SW_W 7
`define QEC_SW_DEFAULT 7'h30
`define QEC_OFS_FLAGS 4'h8
`define QEC_OFS_IACK 4'hC
`define QEC_IRQ_LINES 16
`define QEC_IRQ_VALID 16'b1101_1100_1111_1100
`define QEC_FILT_N 2
`define QEC_CNT_ZERO 24'h00_0000
`define QEC_CNT_MAX 24'hFF_FFFF
`define QEC_IRQ_NONE 4'h0
// Reaction-select bits for carry/borrow: clear, load, irq, pulse.
`define QEC_CB_CLR 0
`define QEC_CB_LOAD 1
`define QEC_CB_IRQ 2
`define QEC_CB_PULSE 3
// Index reaction bits: clear, load, irq.
`define QEC_IX_CLR 0
`define QEC_IX_LOAD 1
`define QEC_IX_IRQ 2
// Flag A modes.
`define QEC_FA_CARRY 2'h0
`define QEC_FA_COMP 2'h1
`define QEC_FA_INDEX 2'h2
`define QEC_FA_CB 2'h3
// Flag B modes.
`define QEC_FB_BORROW 2'h0
`define QEC_FB_DIR 2'h1
`define QEC_FB_ERR 2'h2
`endif

/* File: rtl/qec_counter.v */
// Purpose: Four-axis 24-bit quadrature encoder counter with shared interrupt and ISA-style I/O decode.
// Assumes: One 20 MHz clock; phase, index and aux pins are asynchronous; configuration arrives on plain ports.
// Notes: Axes beyond AXES_USED are held idle, giving the two-axis variant.
`include "qec_map.vh"
`timescale 1ns/1ps
`default_nettype none
module qec_counter #(
  parameter AXES_USED = 4
) (
  input wire i_clk,
  input wire i_rst,
  input wire [`QEC_AXES-1:0] i_phase_a,
  input wire [`QEC_AXES-1:0] i_phase_b,
  input wire [`QEC_AXES-1:0] i_index,
  input wire [`QEC_AXES-1:0] i_aux_clr_load,
  input wire [`QEC_AXES-1:0] i_aux_second,
  input wire [`QEC_AXES-1:0] i_aux_mode,
  input wire [`QEC_AXES*`QEC_CNT_W-1:0] i_preset,
  input wire [`QEC_AXES*4-1:0] i_cb_react,
  input wire [`QEC_AXES*3-1:0] i_idx_react,
  input wire [`QEC_AXES*2-1:0] i_flag_a_mode,
  input wire [`QEC_AXES*2-1:0] i_flag_b_mode,
  input wire [`QEC_SW_W-1:0] i_addr_switch,
  input wire [3:0] i_irq_select,
  input wire [15:0] i_bus_addr,
  input wire i_bus_ior_n,
  input wire i_bus_iow_n,
  input wire i_bus_aen,
  output reg [7:0] o_bus_data,
  output reg o_bus_data_oe,
  output reg [`QEC_IRQ_LINES-1:0] o_irq_lines,
  output reg [`QEC_AXES*`QEC_CNT_W-1:0] o_count,
  output reg [`QEC_AXES-1:0] o_event_flag_out_a,
  output reg [`QEC_AXES-1:0] o_event_flag_out_b
);
  // Two-flop synchronisers for every pin that comes from outside the clock domain.
  reg [`QEC_AXES-1:0] a_s1, a_s2, b_s1, b_s2, ix_s1, ix_s2, x1_s1, x1_s2, x2_s1, x2_s2;
  reg rd_s1, rd_s2, wr_s1, wr_s2;
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      a_s1 <= 4'h0; a_s2 <= 4'h0; b_s1 <= 4'h0; b_s2 <= 4'h0;
      ix_s1 <= 4'h0; ix_s2 <= 4'h0; x1_s1 <= 4'h0; x1_s2 <= 4'h0;
      x2_s1 <= 4'h0; x2_s2 <= 4'h0;
      rd_s1 <= 1'b1; rd_s2 <= 1'b1; wr_s1 <= 1'b1; wr_s2 <= 1'b1;
    end else begin
      a_s1 <= i_phase_a; a_s2 <= a_s1; b_s1 <= i_phase_b; b_s2 <= b_s1;
      ix_s1 <= i_index; ix_s2 <= ix_s1; x1_s1 <= i_aux_clr_load; x1_s2 <= x1_s1;
      x2_s1 <= i_aux_second; x2_s2 <= x2_s1;
      rd_s1 <= i_bus_ior_n; rd_s2 <= rd_s1; wr_s1 <= i_bus_iow_n; wr_s2 <= wr_s1;
    end
  end

  // Address and enable pins pass two flops, like the strobes, so the decode and the synchronised strobe edge
  // see the same cycle. A host that moves the address together with the strobe still decodes cleanly.
  // Upper address lines are ignored, so the card also answers at aliases above 0x7FF.
  reg [`QEC_SW_W+3:0] ad_s1, ad_s2;
  reg aen_s1, aen_s2;
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ad_s1 <= {(`QEC_SW_W+4){1'b0}};
      ad_s2 <= {(`QEC_SW_W+4){1'b0}};
      aen_s1 <= 1'b0;
      aen_s2 <= 1'b0;
    end else begin
      ad_s1 <= i_bus_addr[`QEC_SW_W+3:0];
      ad_s2 <= ad_s1;
      aen_s1 <= i_bus_aen;
      aen_s2 <= aen_s1;
    end
  end

  // Address decode: the switch matches bits 10..4, giving bases 0x000..0x7F0 in 16-byte steps.
  // Only the synchronised copies are read, so a changing address never meets a half-settled strobe.
  wire dec_hit = (ad_s2[`QEC_SW_W+3:4] == i_addr_switch) && !aen_s2;
  reg rd_prev, wr_prev;
  wire rd_act = !rd_s2;
  wire wr_act = !wr_s2;
  wire rd_start = rd_act && rd_prev;
  wire wr_start = wr_act && wr_prev;
  wire iack_hit = dec_hit && (ad_s2[3:0] == `QEC_OFS_IACK);
  wire flag_hit = dec_hit && (ad_s2[3:0] == `QEC_OFS_FLAGS);
  wire iack = iack_hit && (rd_start || wr_start);

  // Per-axis logic.
  reg [`QEC_AXES-1:0] cause;
  reg [`QEC_AXES-1:0] next_cause;
  reg [`QEC_AXES*`QEC_CNT_W-1:0] next_count;
  reg [`QEC_AXES-1:0] next_fa, next_fb, next_err;
  reg [`QEC_AXES-1:0] fa_q, fb_q, fbq_a, fbq_b, ix_prev, err;
  reg [`QEC_FILT_N-1:0] fa_hist [0:`QEC_AXES-1];
  reg [`QEC_FILT_N-1:0] fb_hist [0:`QEC_AXES-1];
  reg [`QEC_AXES-1:0] dir;
  reg [`QEC_AXES-1:0] next_dir;
  integer k;
  integer j; // A loop index of its own, so each index is written by one process only.
  reg [`QEC_CNT_W-1:0] c, pre;
  reg up, dn, carry, borrow, ix_edge, irq_ev, en;
  reg [3:0] cbr;
  reg [2:0] ixr;

  // Counter update: decode, reactions and flags for every axis in one pass.
  always @* begin
    next_count = o_count;
    next_cause = cause;
    next_fa = 4'h0;
    next_fb = 4'h0;
    next_dir = dir;
    next_err = err;
    c = `QEC_CNT_ZERO; pre = `QEC_CNT_ZERO; up = 1'b0; dn = 1'b0;
    carry = 1'b0; borrow = 1'b0; ix_edge = 1'b0; irq_ev = 1'b0; en = 1'b0;
    cbr = 4'h0; ixr = 3'h0;
    for (k = 0; k < `QEC_AXES; k = k + 1) begin
      en = (k < AXES_USED);
      c = o_count[k*`QEC_CNT_W +: `QEC_CNT_W];
      pre = i_preset[k*`QEC_CNT_W +: `QEC_CNT_W];
      cbr = i_cb_react[k*4 +: 4];
      ixr = i_idx_react[k*3 +: 3];
      // Times-four decode: one step per filtered edge of either phase.
      up = en && ((fa_q[k] != fbq_a[k]) && (fa_q[k] != fb_q[k]) ||
                  (fb_q[k] != fbq_b[k]) && (fb_q[k] == fa_q[k])) &&
           !((fa_q[k] != fbq_a[k]) && (fb_q[k] != fbq_b[k]));
      dn = en && ((fa_q[k] != fbq_a[k]) && (fa_q[k] == fb_q[k]) ||
                  (fb_q[k] != fbq_b[k]) && (fb_q[k] != fa_q[k])) &&
           !((fa_q[k] != fbq_a[k]) && (fb_q[k] != fbq_b[k]));
      if (en && (fa_q[k] != fbq_a[k]) && (fb_q[k] != fbq_b[k]))
        next_err[k] = 1'b1; // Both phases moved at once: a lost step.
      carry = up && (c == `QEC_CNT_MAX);
      borrow = dn && (c == `QEC_CNT_ZERO);
      ix_edge = en && ix_s2[k] && !ix_prev[k];
      if (up) begin
        c = c + 24'h00_0001;
        next_dir[k] = 1'b1;
      end else if (dn) begin
        c = c - 24'h00_0001;
        next_dir[k] = 1'b0;
      end
      // Reactions, clear taking priority over load.
      if ((carry || borrow) && cbr[`QEC_CB_LOAD]) c = pre;
      if (ix_edge && ixr[`QEC_IX_LOAD]) c = pre;
      if (en && x1_s2[k] && i_aux_mode[k]) c = pre;
      if (en && x2_s2[k] && i_aux_mode[k]) c = pre;
      if ((carry || borrow) && cbr[`QEC_CB_CLR]) c = `QEC_CNT_ZERO;
      if (ix_edge && ixr[`QEC_IX_CLR]) c = `QEC_CNT_ZERO;
      if (en && (x1_s2[k] || x2_s2[k]) && !i_aux_mode[k]) c = `QEC_CNT_ZERO;
      next_count[k*`QEC_CNT_W +: `QEC_CNT_W] = c;
      // Flag outputs: event pulses, or levels in the compare, direction and error modes.
      case (i_flag_a_mode[k*2 +: 2])
        `QEC_FA_CARRY: next_fa[k] = carry && cbr[`QEC_CB_PULSE];
        `QEC_FA_COMP: next_fa[k] = en && (c == pre);
        `QEC_FA_INDEX: next_fa[k] = ix_edge;
        default: next_fa[k] = (carry || borrow) && cbr[`QEC_CB_PULSE];
      endcase
      case (i_flag_b_mode[k*2 +: 2])
        `QEC_FB_BORROW: next_fb[k] = borrow && cbr[`QEC_CB_PULSE];
        `QEC_FB_DIR: next_fb[k] = next_dir[k];
        `QEC_FB_ERR: next_fb[k] = next_err[k];
        default: next_fb[k] = 1'b0;
      endcase
      // An event in the acknowledge cycle stays pending: set wins over clear.
      irq_ev = ((carry || borrow) && cbr[`QEC_CB_IRQ]) || (ix_edge && ixr[`QEC_IX_IRQ]);
      if (iack) next_cause[k] = 1'b0;
      if (irq_ev) next_cause[k] = 1'b1;
    end
  end

  // Filtered phases, counters and flags.
  // The filter needs a level stable for three samples, so edges closer than 150 ns are rejected.
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      for (j = 0; j < `QEC_AXES; j = j + 1) begin
        fa_hist[j] <= 2'b00;
        fb_hist[j] <= 2'b00;
      end
      fa_q <= 4'h0; fb_q <= 4'h0; fbq_a <= 4'h0; fbq_b <= 4'h0;
      ix_prev <= 4'h0; err <= 4'h0; dir <= 4'h0; cause <= `QEC_IRQ_NONE;
      o_count <= {`QEC_AXES{`QEC_CNT_ZERO}};
      o_event_flag_out_a <= 4'h0; o_event_flag_out_b <= 4'h0;
      rd_prev <= 1'b0; wr_prev <= 1'b0;
    end else begin
      for (j = 0; j < `QEC_AXES; j = j + 1) begin
        fa_hist[j] <= {fa_hist[j][0], a_s2[j]};
        fb_hist[j] <= {fb_hist[j][0], b_s2[j]};
        if (fa_hist[j] == {`QEC_FILT_N{a_s2[j]}}) fa_q[j] <= a_s2[j];
        if (fb_hist[j] == {`QEC_FILT_N{b_s2[j]}}) fb_q[j] <= b_s2[j];
      end
      fbq_a <= fa_q; fbq_b <= fb_q; ix_prev <= ix_s2;
      err <= next_err; dir <= next_dir; cause <= next_cause;
      o_count <= next_count;
      o_event_flag_out_a <= next_fa; o_event_flag_out_b <= next_fb;
      rd_prev <= !rd_act; wr_prev <= !wr_act;
    end
  end

  // Bus read data and shared interrupt routing.
  // Only permitted lines can be driven; an illegal selection drives nothing.
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_bus_data <= 8'h00;
      o_bus_data_oe <= 1'b0;
      o_irq_lines <= 16'h0000;
    end else begin
      o_bus_data_oe <= rd_act && flag_hit;
      o_bus_data <= {4'h0, cause};
      o_irq_lines <= ((|cause) ? (16'h0001 << i_irq_select) : 16'h0000) & `QEC_IRQ_VALID;
    end
  end
endmodule // qec_counter
`default_nettype wire

/* File: verif/qec_counter_sva.sv */
// Purpose: Port checker for the encoder counter.
// Assumes: Configuration inputs held steady while checked.
// Notes: Bound to every counter instance.
`include "qec_map.vh"
`timescale 1ns/1ps
`default_nettype none
module qec_counter_sva (
  input wire i_clk,
  input wire i_rst,
  input wire [3:0] i_phase_a,
  input wire [3:0] i_phase_b,
  input wire [3:0] i_index,
  input wire [3:0] i_aux_clr_load,
  input wire [3:0] i_aux_second,
  input wire [6:0] i_addr_switch,
  input wire [3:0] i_irq_select,
  input wire [15:0] i_bus_addr,
  input wire i_bus_ior_n,
  input wire i_bus_aen,
  input wire [7:0] o_bus_data,
  input wire o_bus_data_oe,
  input wire [15:0] o_irq_lines,
  input wire [95:0] o_count
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Several asserted lines would short host interrupt inputs together.
  irq_one_line_a: assert property ($onehot0(o_irq_lines)) else $error("irq not one-hot");
  irq_legal_a: assert property ((o_irq_lines & ~`QEC_IRQ_VALID) == 16'h0000) else $error("bad irq");
  irq_route_a: assert property (o_irq_lines != 0 |-> o_irq_lines == 16'h0001 << $past(i_irq_select))
    else $error("irq not on selected line");
  upper_zero_a: assert property (o_bus_data_oe |-> o_bus_data[7:4] == 4'h0) else $error("upper nibble");
  read_cause_a: assert property ($rose(o_bus_data_oe) |-> !$past(i_bus_ior_n, 2)
    && $past(i_bus_addr[3:0], 2) == 4'h8) else $error("drive without cause read");
  decode_window_a: assert property ($rose(o_bus_data_oe) |-> !$past(i_bus_aen, 2)
    && $past(i_bus_addr[10:4], 2) == i_addr_switch) else $error("drive outside window");
  // Eight quiet cycles cover the sync and filter latency of any earlier edge.
  quiet_count_a: assert property (($stable(i_phase_a) && $stable(i_phase_b) && $stable(i_index)
    && i_aux_clr_load == 0 && i_aux_second == 0)[*8] |=> $stable(o_count)) else $error("count moved");
  rst_quiet_a: assert property (disable iff (1'b0) i_rst |-> o_count == 0 && o_irq_lines == 0)
    else $error("outputs live in reset");
endmodule // qec_counter_sva
bind qec_counter qec_counter_sva qec_counter_sva_inst (.i_clk(i_clk), .i_rst(i_rst), .i_phase_a(i_phase_a),
  .i_phase_b(i_phase_b), .i_index(i_index), .i_aux_clr_load(i_aux_clr_load), .i_aux_second(i_aux_second),
  .i_addr_switch(i_addr_switch), .i_irq_select(i_irq_select), .i_bus_addr(i_bus_addr),
  .i_bus_ior_n(i_bus_ior_n), .i_bus_aen(i_bus_aen), .o_bus_data(o_bus_data),
  .o_bus_data_oe(o_bus_data_oe), .o_irq_lines(o_irq_lines), .o_count(o_count));
`default_nettype wire

/* File: verif/qec_host_model.sv */
// Purpose: Host bus model issuing I/O cycles.
// Assumes: Answer within three clocks of the strobe.
// Notes: Released address lines show the inverse value.
`timescale 1ns/1ps
`default_nettype none
module qec_host_model (
  input wire i_clk,
  input wire [7:0] i_bus_data,
  input wire i_bus_data_oe,
  output logic [15:0] o_bus_addr,
  output logic o_bus_ior_n,
  output logic o_bus_iow_n,
  output logic o_bus_aen
);
  // Idle bus: strobes high, no DMA cycle in progress.
  initial begin
    o_bus_addr = 16'hFFFF;
    o_bus_ior_n = 1'b1;
    o_bus_iow_n = 1'b1;
    o_bus_aen = 1'b0;
  end
  // Strobe held six clocks so the answer is taken inside it.
  task automatic io_access(input logic wr, input logic [15:0] a, output logic [7:0] d, output logic oe);
    o_bus_addr <= a;
    o_bus_ior_n <= wr;
    o_bus_iow_n <= !wr;
    repeat (6) @(posedge i_clk);
    d = i_bus_data;
    oe = i_bus_data_oe;
    o_bus_ior_n <= 1'b1;
    o_bus_iow_n <= 1'b1;
    o_bus_addr <= ~a;
    repeat (5) @(posedge i_clk);
  endtask
endmodule // qec_host_model
`default_nettype wire

/* File: verif/qec_counter_test.sv */
// Purpose: Self-checking bench for the encoder counter.
// Assumes: Phase edges four clocks apart.
// Notes: Host cycles go through the host model.
`timescale 1ns/1ps
`default_nettype none
module qec_counter_test;
  logic i_clk = 0, i_rst = 0;
  logic [3:0] pa = 0, pb = 0, idx = 0, aux1 = 0, aux2 = 0, amode = 0, irqsel = 4'h5;
  logic [95:0] preset = 0;
  logic [15:0] cbr = 0;
  logic [11:0] ixr = 0;
  logic [6:0] sw = 7'h30;
  logic [1:0] q [4] = '{default: 2'd0};
  logic [7:0] d;
  logic [7:0] fam = 0, fbm = 0;
  wire [3:0] fla, flb;
  logic oe_seen;
  wire [15:0] addr, irq;
  wire ior_n, iow_n, aen, oe;
  wire [7:0] data;
  wire [95:0] cnt;
  int failures = 0, n_checks = 0;
  qec_counter qec_counter_inst (.i_clk(i_clk), .i_rst(i_rst), .i_phase_a(pa), .i_phase_b(pb), .i_index(idx),
    .i_aux_clr_load(aux1), .i_aux_second(aux2), .i_aux_mode(amode), .i_preset(preset), .i_cb_react(cbr),
    .i_idx_react(ixr), .i_flag_a_mode(fam), .i_flag_b_mode(fbm), .i_addr_switch(sw),
    .i_irq_select(irqsel), .i_bus_addr(addr), .i_bus_ior_n(ior_n), .i_bus_iow_n(iow_n), .i_bus_aen(aen),
    .o_bus_data(data), .o_bus_data_oe(oe), .o_irq_lines(irq), .o_count(cnt), .o_event_flag_out_a(fla),
    .o_event_flag_out_b(flb));
  qec_host_model qec_host_model_inst (.i_clk(i_clk), .i_bus_data(data), .i_bus_data_oe(oe),
    .o_bus_addr(addr), .o_bus_ior_n(ior_n), .o_bus_iow_n(iow_n), .o_bus_aen(aen));
  initial forever #25 i_clk = ~i_clk;
  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    if (failures == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // One Gray step; A leading B counts up.
  task automatic step(input int ax, input bit up);
    q[ax] = up ? q[ax] + 2'd1 : q[ax] - 2'd1;
    pa[ax] <= q[ax][1] ^ q[ax][0];
    pb[ax] <= q[ax][1];
    repeat (4) @(posedge i_clk);
  endtask
  // Bounded wait; running out ends the run.
  task automatic wait_irq(input logic [15:0] exp);
    int n;
    for (n = 0; n < 20 && irq !== exp; n++) @(posedge i_clk);
    chk(irq, exp);
    if (n == 20) end_of_test();
  endtask
  task automatic t_count;
    repeat (4) step(0, 1);
    repeat (6) @(posedge i_clk);
    chk(cnt[23:0], 24'd4);
    repeat (2) step(0, 0);
    pa[0] <= ~pa[0];
    @(posedge i_clk);
    pa[0] <= ~pa[0];
    repeat (8) @(posedge i_clk);
    chk(cnt[23:0], 24'd2);
    chk(cnt[47:24], 24'd0);
  endtask
  task automatic t_aux;
    preset[47:24] <= 24'h12_3456;
    amode <= 4'b0110;
    aux1[1] <= 1'b1;
    @(posedge i_clk);
    aux1[1] <= 1'b0;
    repeat (8) @(posedge i_clk);
    chk(cnt[47:24], 24'h12_3456);
    amode[1] <= 1'b0;
    aux2[1] <= 1'b1;
    @(posedge i_clk);
    aux2[1] <= 1'b0;
    repeat (8) @(posedge i_clk);
    chk(cnt[47:24], 24'd0);
  endtask
  task automatic t_carry;
    preset[71:48] <= 24'hFF_FFFF;
    cbr <= 16'h0400;
    aux1[2] <= 1'b1;
    @(posedge i_clk);
    aux1[2] <= 1'b0;
    repeat (8) @(posedge i_clk);
    step(2, 1);
    wait_irq(16'h0020);
    chk(cnt[71:48], 24'd0);
    qec_host_model_inst.io_access(1'b0, 16'h0308, d, oe_seen);
    chk(d, 8'h04);
    qec_host_model_inst.io_access(1'b0, 16'h0318, d, oe_seen);
    chk(oe_seen, 1'b0);
    qec_host_model_inst.io_access(1'b1, 16'h030C, d, oe_seen);
    wait_irq(16'h0000);
  endtask
  task automatic t_index;
    ixr <= 12'h801;
    idx <= 4'b1001;
    sw <= 7'h7F;
    repeat (8) @(posedge i_clk);
    chk(cnt[23:0], 24'd0);
    qec_host_model_inst.io_access(1'b0, 16'h07F8, d, oe_seen);
    chk(d, 8'h08);
    // Line 13 is not wired on the card, so a pending request must drive nothing there.
    irqsel <= 4'hD;
    wait_irq(16'h0000);
    irqsel <= 4'h5;
    wait_irq(16'h0020);
    qec_host_model_inst.io_access(1'b0, 16'h07FC, d, oe_seen);
    wait_irq(16'h0000);
  endtask
  // Axis 0 compare and direction flags, axis 1 error flag on a double phase change.
  task automatic t_flags;
    fam <= 8'h01;
    fbm <= 8'h09;
    repeat (8) @(posedge i_clk);
    chk(fla, 4'h1);
    chk(flb, 4'h0);
    pa[1] <= 1'b1;
    pb[1] <= 1'b1;
    @(posedge i_clk);
    step(0, 1);
    repeat (4) @(posedge i_clk);
    chk(fla, 4'h0);
    chk(flb, 4'h3);
    chk(cnt[23:0], 24'd1);
    chk(cnt[47:24], 24'd0);
  endtask
  initial begin
    // A real rising edge at time zero, so the asynchronous reset acts before the first clock.
    i_rst <= 1'b1;
    repeat (3) @(posedge i_clk);
    chk(irq, 16'h0000);
    i_rst <= 1'b0;
    @(posedge i_clk);
    t_count;
    t_aux;
    t_carry;
    t_index;
    t_flags;
    end_of_test;
  end
endmodule // qec_counter_test
`default_nettype wire
